// ===== inc/avfc_regs.svh
`ifndef AVFC_REGS_SVH
`define AVFC_REGS_SVH
// ==========================================
// Register offsets (byte addresses)
`define AVFC_CONV_OFF 12'h068
`define AVFC_EVEN_VTC_OFF 12'h06C
`define AVFC_ODD_VTC_OFF 12'h0EC
`define AVFC_STATUS_OFF 12'h0F0
// ==========================================
// Reset values
`define AVFC_CONV_RST 8'h82
`define AVFC_VTC_RST 8'h00
// ==========================================
// Converter control fields
`define AVFC_CONV_RSVD_HI 7
`define AVFC_CONV_RSVD_LO 6
`define AVFC_CONV_SYNC_LOW 5
`define AVFC_CONV_GAIN_DIS 4
`define AVFC_CONV_CLK_DOWN 3
`define AVFC_CONV_LUMA_SLEEP 2
`define AVFC_CONV_CHROMA_SLEEP 1
`define AVFC_CONV_ADAPT 0
// ==========================================
// Filter control and scaling fields
`define AVFC_VTC_TAP_HI 1
`define AVFC_VTC_TAP_LO 0
`define AVFC_VSU_LUMA_COMB 7
`endif

// ===== inc/avfc_pkg.sv
`default_nettype none
package avfc_pkg;
    typedef logic [1:0] avfc_tap_t;
    // Filter setup handed to the scaler for one field
    typedef struct packed {
        logic [2:0] avg_taps;
        logic interp_en;
        logic [3:0] weight_shift;
    } avfc_filt_cfg_s;
    // Decoded converter controls
    typedef struct packed {
        logic sync_thresh_low;
        logic sys_clk_down;
        logic luma_sleep;
        logic chroma_sleep;
    } avfc_conv_ctl_s;
endpackage
`default_nettype wire

// ===== rtl/avfc_ctrl.sv
// Our own choice: register access over APB.
`include "avfc_regs.svh"
`default_nettype none
module avfc_ctrl
    import avfc_pkg::*;
#(
    parameter int unsigned GAIN_W = 8,
    parameter logic [GAIN_W-1:0] GAIN_NOMINAL = 8'h80
) (
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    // ==========================================
    // APB slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic pready_o,
    output logic [31:0] prdata_o,
    output logic pslverr_o,
    // ==========================================
    // Scaler and converter side
    input wire logic [7:0] vscale_upper_even_i,
    input wire logic [7:0] vscale_upper_odd_i,
    input wire logic converter_overflow_i,
    output avfc_conv_ctl_s conv_ctl_o,
    output logic [GAIN_W-1:0] gain_reference_output_o,
    output logic gain_reference_output_oe_o,
    output avfc_filt_cfg_s [1:0] filt_cfg_o
);
    // ==========================================
    // Bus decode
    logic [7:0] conv_q;
    logic [7:0] vtc_q [2];
    logic [GAIN_W-1:0] gain_level_q;
    logic pready_q;
    logic [31:0] prdata_q;
    logic pslverr_q;
    logic setup;
    logic access;
    logic wr_en;
    logic hit_conv;
    logic hit_even;
    logic hit_odd;
    logic hit_stat;
    logic [7:0] rd_byte;

    assign setup = psel_i && !penable_i;
    assign access = psel_i && penable_i && pready_q;
    assign wr_en = access && pwrite_i && pstrb_i[0];
    assign hit_conv = paddr_i == `AVFC_CONV_OFF;
    assign hit_even = paddr_i == `AVFC_EVEN_VTC_OFF;
    assign hit_odd = paddr_i == `AVFC_ODD_VTC_OFF;
    assign hit_stat = paddr_i == `AVFC_STATUS_OFF;

    always_comb begin
        rd_byte = 8'h00;
        if (hit_conv) begin
            rd_byte = conv_q;
        end else if (hit_even) begin
            rd_byte = vtc_q[0];
        end else if (hit_odd) begin
            rd_byte = vtc_q[1];
        end
    end

    // Answer is prepared in setup so that pready and prdata come from flops
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pready_q <= 1'b0;
        end else begin
            pready_q <= setup;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            prdata_q <= 32'h0000_0000;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            pslverr_q <= !(hit_conv || hit_even || hit_odd || (hit_stat && !pwrite_i));
            if (hit_stat) begin
                prdata_q <= {{(24 - GAIN_W){1'b0}}, gain_level_q, 8'h00};
            end else begin
                prdata_q <= {24'h00_0000, rd_byte};
            end
        end
    end

    assign pready_o = pready_q;
    assign prdata_o = prdata_q;
    assign pslverr_o = pslverr_q;

    // ==========================================
    // Converter control register
    // Reserved bits are stored as written so software sees its own value back
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_q <= `AVFC_CONV_RST;
        end else if (wr_en && hit_conv) begin
            conv_q <= pwdata_i[7:0];
        end
    end

    // ==========================================
    // Per-field filter registers and tap decode
    function automatic avfc_filt_cfg_s tap_decode(input logic comb, input avfc_tap_t code);
        avfc_filt_cfg_s cfg;
        cfg = '0;
        if (comb) begin
            cfg.avg_taps = 3'(code) + 3'd2;
            cfg.interp_en = 1'b0;
            cfg.weight_shift = 4'(code) + 4'd1;
        end else if (code == 2'b00) begin
            cfg.avg_taps = 3'd0;
            cfg.interp_en = 1'b1;
            cfg.weight_shift = 4'd0;
        end else begin
            cfg.avg_taps = 3'(code) + 3'd1;
            cfg.interp_en = 1'b1;
            cfg.weight_shift = 4'(code);
        end
        return cfg;
    endfunction

    logic [1:0] comb_sel;
    assign comb_sel[0] = vscale_upper_even_i[`AVFC_VSU_LUMA_COMB];
    assign comb_sel[1] = vscale_upper_odd_i[`AVFC_VSU_LUMA_COMB];

    for (genvar f = 0; f < 2; f++) begin : g_field
        logic hit;
        assign hit = (f == 0) ? hit_even : hit_odd;

        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                vtc_q[f] <= `AVFC_VTC_RST;
            end else if (wr_en && hit) begin
                vtc_q[f] <= pwdata_i[7:0];
            end
        end

        // Pixel-count limits on codes are left to software; the buffer is not checked here
        always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                filt_cfg_o[f] <= '0;
            end else begin
                filt_cfg_o[f] <= tap_decode(comb_sel[f], vtc_q[f][`AVFC_VTC_TAP_HI:`AVFC_VTC_TAP_LO]);
            end
        end
    end

    // ==========================================
    // Decoded converter controls
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            conv_ctl_o <= '{sync_thresh_low: 1'b0, sys_clk_down: 1'b0, luma_sleep: 1'b0, chroma_sleep: 1'b1};
        end else begin
            conv_ctl_o.sync_thresh_low <= conv_q[`AVFC_CONV_SYNC_LOW];
            // Only the sampling core stops; this bank and the bus keep the free clock
            conv_ctl_o.sys_clk_down <= conv_q[`AVFC_CONV_CLK_DOWN];
            conv_ctl_o.luma_sleep <= conv_q[`AVFC_CONV_LUMA_SLEEP];
            conv_ctl_o.chroma_sleep <= conv_q[`AVFC_CONV_CHROMA_SLEEP];
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_reference_output_oe_o <= 1'b0;
        end else begin
            gain_reference_output_oe_o <= !conv_q[`AVFC_CONV_GAIN_DIS];
        end
    end

    // ==========================================
    // Overflow input: three flops, change accepted when the last two agree
    logic ovf_s1_q;
    logic ovf_s2_q;
    logic ovf_s3_q;
    logic ovf_state_q;
    logic ovf_event;

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_s1_q <= 1'b0;
            ovf_s2_q <= 1'b0;
            ovf_s3_q <= 1'b0;
        end else begin
            ovf_s1_q <= converter_overflow_i;
            ovf_s2_q <= ovf_s1_q;
            ovf_s3_q <= ovf_s2_q;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ovf_state_q <= 1'b0;
        end else if (ovf_s2_q == ovf_s3_q) begin
            ovf_state_q <= ovf_s3_q;
        end
    end

    assign ovf_event = (ovf_s2_q == ovf_s3_q) && ovf_s3_q && !ovf_state_q;

    // ==========================================
    // Gain reference level
    // Saturates at full scale; falls back to nominal when adaptive mode is off
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_level_q <= '0;
        end else if (!conv_q[`AVFC_CONV_ADAPT]) begin
            gain_level_q <= GAIN_NOMINAL;
        end else if (ovf_event && !(&gain_level_q)) begin
            gain_level_q <= gain_level_q + 1'b1;
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gain_reference_output_o <= '0;
        end else begin
            gain_reference_output_o <= gain_level_q;
        end
    end

    // ==========================================
    // Checks
    logic live_q;
    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            live_q <= 1'b0;
        end else begin
            live_q <= 1'b1;
        end
    end

    sequence s_conv_write;
        wr_en && hit_conv;
    endsequence

    sequence s_overflow_adapt;
        ovf_event && conv_q[`AVFC_CONV_ADAPT] && !(&gain_level_q);
    endsequence

    sequence s_masked_write;
        access && pwrite_i && !pstrb_i[0];
    endsequence

    a_reset_defaults: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !live_q |-> conv_q == `AVFC_CONV_RST && vtc_q[0] == `AVFC_VTC_RST && vtc_q[1] == `AVFC_VTC_RST)
        else $error("Register defaults wrong after reset");

    a_conv_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_conv_write |=> conv_q == $past(pwdata_i[7:0]))
        else $error("Converter control write lost");

    a_read_back: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        setup && !pwrite_i && hit_conv |=> prdata_o[7:0] == $past(conv_q) && pready_o && !pslverr_o)
        else $error("Converter control read back wrong");

    a_sync_thresh: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_conv_write ##1 1'b1 |=> conv_ctl_o.sync_thresh_low == $past(pwdata_i[5], 2))
        else $error("Sync threshold select not followed");

    a_gain_drive: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        live_q |=> gain_reference_output_oe_o == !$past(conv_q[`AVFC_CONV_GAIN_DIS]))
        else $error("Gain reference drive wrong");

    a_clk_down: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(conv_q[`AVFC_CONV_CLK_DOWN]) |=> conv_ctl_o.sys_clk_down)
        else $error("Clock power-down not asserted");

    a_luma_sleep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        conv_q[`AVFC_CONV_LUMA_SLEEP] [*2] |-> conv_ctl_o.luma_sleep)
        else $error("Luma converter not asleep");

    a_chroma_sleep: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !live_q |-> conv_ctl_o.chroma_sleep)
        else $error("Chroma converter awake after reset");

    a_gain_raise: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_overflow_adapt |=> gain_level_q == $past(gain_level_q) + 1'b1)
        else $error("Overflow did not raise gain");

    a_gain_fixed: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !conv_q[`AVFC_CONV_ADAPT] |=> gain_level_q == GAIN_NOMINAL)
        else $error("Gain moved in non-adaptive mode");

    a_tap_comb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        comb_sel[0] && vtc_q[0][1:0] == 2'b11 |=> filt_cfg_o[0].avg_taps == 3'd5 && !filt_cfg_o[0].interp_en)
        else $error("Comb five-tap decode wrong");

    a_tap_plain: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        !comb_sel[1] && vtc_q[1][1:0] == 2'b00 |=> filt_cfg_o[1].avg_taps == 3'd0 && filt_cfg_o[1].interp_en)
        else $error("Interpolation-only decode wrong");

    a_unmapped: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        setup && !(hit_conv || hit_even || hit_odd || hit_stat) |=> pslverr_o && pready_o)
        else $error("Unmapped access not refused");

    a_status_refused: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        setup && pwrite_i && hit_stat |=> pslverr_o && pready_o)
        else $error("Status write not refused");

    a_even_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_en && hit_even |=> vtc_q[0] == $past(pwdata_i[7:0]))
        else $error("Even filter write lost");

    a_odd_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        wr_en && hit_odd |=> vtc_q[1] == $past(pwdata_i[7:0]))
        else $error("Odd filter write lost");

    a_masked_write: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        s_masked_write |=> $stable(conv_q) && $stable(vtc_q[0]) && $stable(vtc_q[1]))
        else $error("Write without low byte strobe changed a register");

    a_gain_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        live_q |=> gain_reference_output_o == $past(gain_level_q))
        else $error("Gain reference output does not follow level");

    a_gain_saturate: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        ovf_event && conv_q[`AVFC_CONV_ADAPT] && (&gain_level_q) |=> &gain_level_q)
        else $error("Gain level wrapped past full scale");

    a_tap_odd_comb: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        comb_sel[1] && vtc_q[1][1:0] == 2'b00 |=> filt_cfg_o[1].avg_taps == 3'd2 && filt_cfg_o[1].weight_shift == 4'd1)
        else $error("Comb two-tap decode wrong");

    a_chroma_follow: assert property (@(posedge clk_sys_i) disable iff (!rst_n_i)
        live_q |=> conv_ctl_o.chroma_sleep == $past(conv_q[`AVFC_CONV_CHROMA_SLEEP]))
        else $error("Chroma sleep does not follow its bit");
endmodule
`default_nettype wire

// ===== testbench/adc_and_vertical_filter_ctrl_bench.sv
`include "avfc_regs.svh"
`default_nettype none
module adc_and_vertical_filter_ctrl_bench import avfc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic psel_i = 1'b0;
    logic penable_i = 1'b0;
    logic pwrite_i = 1'b0;
    logic [11:0] paddr_i = 12'h000;
    logic [31:0] pwdata_i = 32'h0000_0000;
    logic [3:0] pstrb_i = 4'hf;
    logic [7:0] vs_even = 8'h00;
    logic [7:0] vs_odd = 8'h00;
    logic ovf = 1'b0;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    avfc_conv_ctl_s conv_ctl;
    logic [7:0] gain;
    logic gain_oe;
    avfc_filt_cfg_s [1:0] filt;
    int miscompares = 0;
    int samples_checked = 0;
    int cycles = 0;
    logic [7:0] seed = 8'h45;
    logic [7:0] v;
    logic [31:0] rd;
    logic err;

    avfc_ctrl u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
        .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pstrb_i(pstrb_i), .pready_o(pready),
        .prdata_o(prdata), .pslverr_o(pslverr), .vscale_upper_even_i(vs_even), .vscale_upper_odd_i(vs_odd),
        .converter_overflow_i(ovf), .conv_ctl_o(conv_ctl), .gain_reference_output_o(gain),
        .gain_reference_output_oe_o(gain_oe), .filt_cfg_o(filt));

    // ==========================================
    // Clock, timeout and helpers
    initial begin
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end

    // The whole run needs about 1350 cycles
    always @(posedge clk_sys_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            end_of_test();
        end
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    function automatic avfc_filt_cfg_s exp_filt(input logic comb, input logic [1:0] k);
        avfc_filt_cfg_s f;
        f.avg_taps = comb ? 3'(k) + 3'h2 : ((k == 2'h0) ? 3'h0 : 3'(k) + 3'h1);
        f.interp_en = ~comb;
        f.weight_shift = comb ? 4'(k) + 4'h1 : 4'(k);
        return f;
    endfunction

    task automatic wt(input int n);
        repeat (n) @(posedge clk_sys_i);
    endtask

    task automatic chk(input string name, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("[FAIL] %s expected %h seen %h", name, e, g);
            miscompares++;
        end
    endtask

    // Request is held until pready is seen high at a rising edge
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
        @(posedge clk_sys_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= wr;
        paddr_i <= a;
        pwdata_i <= d;
        pstrb_i <= s;
        @(posedge clk_sys_i);
        penable_i <= 1'b1;
        // No cycle count is assumed; only the bench timeout ends a hung transfer
        do begin
            @(posedge clk_sys_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0000_0000, 4'hf);
        chk(name, e, rd);
    endtask

    task automatic do_reset();
        rst_n_i <= 1'b0;
        wt(12);
        rst_n_i <= 1'b1;
        rd_chk("conv reset", `AVFC_CONV_OFF, 32'h0000_0082);
        rd_chk("even reset", `AVFC_EVEN_VTC_OFF, 32'h0000_0000);
        rd_chk("odd reset", `AVFC_ODD_VTC_OFF, 32'h0000_0000);
        chk("ctl reset", 32'h0000_0001, 32'(conv_ctl));
        chk("oe reset", 32'h0000_0001, 32'(gain_oe));
        rd_chk("gain reset", `AVFC_STATUS_OFF, 32'h0000_8000);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            ovf <= 1'b1;
            wt(4);
            ovf <= 1'b0;
            wt(4);
        end
        wt(2);
    endtask

    task automatic end_of_test();
        $display("samples_checked %0d miscompares %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        do_reset();
        // Reserved top bits kept at one-zero as software must
        repeat (10) begin
            seed = lfsr(seed);
            v = {2'h2, seed[5:0]};
            // Power-down only flags the core, so the bank needs no recovery wait here
            apb(1'b1, `AVFC_CONV_OFF, {24'h00_0000, v}, 4'hf);
            wt(3);
            chk("conv ctl", {28'h000_0000, v[5], v[3], v[2], v[1]}, 32'(conv_ctl));
            chk("gain oe", {31'h0000_0000, ~v[4]}, 32'(gain_oe));
            rd_chk("conv readback", `AVFC_CONV_OFF, {24'h00_0000, v});
        end
        // The bench stands for a line of fewer than 193 active pixels, so every tap code is allowed
        for (int c = 0; c < 2; c++) begin
            for (int k = 0; k < 4; k++) begin
                seed = lfsr(seed);
                vs_even <= {c[0], seed[6:0]};
                vs_odd <= {~c[0], seed[6:0]};
                apb(1'b1, `AVFC_EVEN_VTC_OFF, {30'h0000_0000, k[1:0]}, 4'hf);
                apb(1'b1, `AVFC_ODD_VTC_OFF, {30'h0000_0000, ~k[1:0]}, 4'hf);
                wt(3);
                chk("even filt", 32'(exp_filt(c[0], k[1:0])), 32'(filt[0]));
                chk("odd filt", 32'(exp_filt(~c[0], ~k[1:0])), 32'(filt[1]));
                rd_chk("even readback", `AVFC_EVEN_VTC_OFF, {30'h0000_0000, k[1:0]});
                rd_chk("odd readback", `AVFC_ODD_VTC_OFF, {30'h0000_0000, ~k[1:0]});
            end
        end
        // Refused and ignored accesses must leave registers untouched
        apb(1'b1, 12'h070, 32'h0000_00ff, 4'hf);
        chk("unmapped wr err", 32'h0000_0001, 32'(err));
        apb(1'b0, 12'h070, 32'h0000_0000, 4'hf);
        chk("unmapped rd err", 32'h0000_0001, 32'(err));
        chk("unmapped rd data", 32'h0000_0000, rd);
        apb(1'b1, `AVFC_EVEN_VTC_OFF, 32'h0000_0001, 4'he);
        rd_chk("strobe ignored", `AVFC_EVEN_VTC_OFF, 32'h0000_0003);
        // Adaptive gain: one step per overflow rise, saturating
        apb(1'b1, `AVFC_CONV_OFF, 32'h0000_0080, 4'hf);
        pulses(2);
        chk("gain non adaptive", 32'h0000_0080, 32'(gain));
        apb(1'b1, `AVFC_CONV_OFF, 32'h0000_0081, 4'hf);
        pulses(3);
        chk("gain step", 32'h0000_0083, 32'(gain));
        rd_chk("gain status", `AVFC_STATUS_OFF, 32'h0000_8300);
        apb(1'b1, `AVFC_STATUS_OFF, 32'h0000_0000, 4'hf);
        chk("status wr err", 32'h0000_0001, 32'(err));
        rd_chk("status kept", `AVFC_STATUS_OFF, 32'h0000_8300);
        pulses(126);
        chk("gain saturate", 32'h0000_00ff, 32'(gain));
        apb(1'b1, `AVFC_CONV_OFF, 32'h0000_0080, 4'hf);
        wt(4);
        chk("gain back nominal", 32'h0000_0080, 32'(gain));
        do_reset();
        end_of_test();
    end
endmodule
`default_nettype wire
